// ### design/adc_pkg.sv
/*
 adc_pkg: constants and types of the audio core datapath.
 assumes: used by adc_core and adc_mem with scoped names only.
*/
package adc_pkg;
  localparam int SAMPLE_W = 24;
  localparam int CORE_W = 28;
  localparam int HEADROOM_W = 4;
  localparam int PROG_DEPTH = 512;
  localparam int PC_W = 9;
  localparam int INSTR_W = 32;
  localparam int DATA_DEPTH = 512;
  localparam int ADDR_W = 9;
  localparam int CH_N = 2;
  // rate settings: instructions per sample
  localparam logic [1:0] RATE_NORMAL = 2'h0;
  localparam logic [1:0] RATE_DOUBLE = 2'h1;
  localparam logic [1:0] RATE_QUAD = 2'h2;
  localparam logic [PC_W:0] LEN_NORMAL = 10'h200;
  localparam logic [PC_W:0] LEN_DOUBLE = 10'h100;
  localparam logic [PC_W:0] LEN_QUAD = 10'h080;
  // instruction fields
  localparam int OP_LSB = 28;
  localparam int OP_W = 4;
  localparam int IADDR_LSB = 0;
  localparam logic [OP_W-1:0] OP_NOP = 4'h0;
  localparam logic [OP_W-1:0] OP_LOAD_IN = 4'h1;
  localparam logic [OP_W-1:0] OP_LOAD_MEM = 4'h2;
  localparam logic [OP_W-1:0] OP_MUL_PARAM = 4'h3;
  localparam logic [OP_W-1:0] OP_ADD_MEM = 4'h4;
  localparam logic [OP_W-1:0] OP_STORE_MEM = 4'h5;
  localparam logic [OP_W-1:0] OP_STORE_OUT = 4'h6;
  localparam logic [CORE_W-1:0] ACC_RESET = 28'h0000000;
  localparam logic [CORE_W-1:0] UNITY = 28'h0800000;
  localparam logic [CORE_W-1:0] CLIP_POS = 28'h07FFFFF;
  localparam logic [CORE_W-1:0] CLIP_NEG = 28'hF800000;
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } adc_state_t;
endpackage

// ### design/adc_mem_if.sv
/*
 adc_mem_if: port bundle between the core and its memory.
 assumes: one clock; the core drives requests, the memory answers.
*/
`timescale 1ns/100ps
interface adc_mem_if;
  logic we;
  logic [adc_pkg::ADDR_W-1:0] waddr;
  logic [adc_pkg::ADDR_W-1:0] raddr;
  logic [adc_pkg::CORE_W-1:0] wdata;
  logic [adc_pkg::CORE_W-1:0] rdata;
  modport core (output we, output waddr, output raddr, output wdata, input rdata);
  modport mem (input we, input waddr, input raddr, input wdata, output rdata);
endinterface

// ### design/adc_mem.sv
/*
 adc_mem: data memory with one write and one registered read port.
 assumes: clk shared with the core, no reset; reads land one cycle later.
*/
`timescale 1ns/100ps
module adc_mem (
  input wire logic clk, // clock
  adc_mem_if.mem port_i // memory port
);
  logic [adc_pkg::CORE_W-1:0] mem_q [adc_pkg::DATA_DEPTH];
  logic [adc_pkg::CORE_W-1:0] rdata_q;
  logic [adc_pkg::CORE_W-1:0] rdata_d;

  always_comb begin
    rdata_d = mem_q[port_i.raddr];
  end

  always_ff @(posedge clk) begin
    if (port_i.we) begin
      mem_q[port_i.waddr] <= port_i.wdata;
    end
    rdata_q <= rdata_d;
  end

  assign port_i.rdata = rdata_q;
endmodule // adc_mem

// ### design/adc_core.sv
/*
 adc_core: sequencer and 5.23 datapath of a stream audio processor.
 assumes: one clock; sample_strobe marks each sample period; program and
 parameter loading beyond boot comes through the load port when selected.
*/
`timescale 1ns/100ps
module adc_core (
  input wire logic clk, // master clock
  input wire logic reset_active_low, // asynchronous pin, low resets
  input wire logic self_boot, // pin: high leaves init for run, low waits and enables the load port
  input wire logic [1:0] rate_sel, // instructions-per-sample setting
  input wire logic mute, // output mute control
  input wire logic sample_strobe, // one-cycle start of sample period
  input wire logic [adc_pkg::SAMPLE_W-1:0] in_left, // left input sample
  input wire logic [adc_pkg::SAMPLE_W-1:0] in_right, // right input sample
  input wire logic load_we, // external program or parameter write strobe
  input wire logic load_sel, // 0 program word, 1 parameter word
  input wire logic [adc_pkg::PC_W-1:0] load_addr, // external load address
  input wire logic [adc_pkg::INSTR_W-1:0] load_data, // external load data
  output logic init_done, // initialization finished
  output logic [adc_pkg::SAMPLE_W-1:0] out_left, // clipped left output
  output logic [adc_pkg::SAMPLE_W-1:0] out_right // clipped right output
);
  localparam int PW = adc_pkg::PC_W;
  localparam int CW = adc_pkg::CORE_W;
  localparam int SW = adc_pkg::SAMPLE_W;

  // boot program: pass each input to its output
  function automatic logic [adc_pkg::INSTR_W-1:0] boot_instr(input logic [PW-1:0] a);
    case (a)
      9'h000: boot_instr = {adc_pkg::OP_LOAD_IN, 28'h0000000};
      9'h001: boot_instr = {adc_pkg::OP_STORE_OUT, 28'h0000000};
      9'h002: boot_instr = {adc_pkg::OP_LOAD_IN, 28'h0000001};
      9'h003: boot_instr = {adc_pkg::OP_STORE_OUT, 28'h0000001};
      default: boot_instr = {adc_pkg::OP_NOP, 28'h0000000};
    endcase
  endfunction

  function automatic logic [CW-1:0] sext(input logic [SW-1:0] s);
    sext = {{adc_pkg::HEADROOM_W{s[SW-1]}}, s};
  endfunction

  function automatic logic [SW-1:0] clip(input logic [CW-1:0] v);
    if ($signed(v) > $signed(adc_pkg::CLIP_POS)) begin
      clip = adc_pkg::CLIP_POS[SW-1:0];
    end else if ($signed(v) < $signed(adc_pkg::CLIP_NEG)) begin
      clip = adc_pkg::CLIP_NEG[SW-1:0];
    end else begin
      clip = v[SW-1:0];
    end
  endfunction

  // reset and self boot pin synchroniser
  logic rst_s1_q;
  logic rst_s2_q;
  logic boot_s1_q;
  logic boot_s2_q;
  always_ff @(posedge clk) begin
    rst_s1_q <= reset_active_low;
    rst_s2_q <= rst_s1_q;
    boot_s1_q <= self_boot;
    boot_s2_q <= boot_s1_q;
  end
  logic rst;
  assign rst = ~rst_s2_q;

  logic [adc_pkg::INSTR_W-1:0] prog_q [adc_pkg::PROG_DEPTH];
  logic [CW-1:0] param_q [adc_pkg::PROG_DEPTH];

  adc_pkg::adc_state_t state_q, state_d;
  logic [PW:0] cnt_q, cnt_d;
  logic [PW-1:0] pc_q, pc_d;
  logic running_q, running_d;
  logic [CW-1:0] acc_q, acc_d;
  logic [SW-1:0] out_l_q, out_l_d, out_r_q, out_r_d;
  logic [CW-1:0] in_l_q, in_l_d, in_r_q, in_r_d;
  logic init_done_q, init_done_d;
  logic [PW:0] pass_len;
  logic [adc_pkg::INSTR_W-1:0] instr;
  logic [adc_pkg::OP_W-1:0] op;
  logic [PW-1:0] iaddr;
  logic signed [2*CW-1:0] prod;
  adc_mem_if dm ();

  adc_mem u_mem (
    .clk(clk),
    .port_i(dm.mem)
  );

  always_comb begin
    case (rate_sel)
      adc_pkg::RATE_DOUBLE: pass_len = adc_pkg::LEN_DOUBLE;
      adc_pkg::RATE_QUAD: pass_len = adc_pkg::LEN_QUAD;
      default: pass_len = adc_pkg::LEN_NORMAL;
    endcase
  end

  assign instr = prog_q[pc_q];
  assign op = instr[adc_pkg::OP_LSB +: adc_pkg::OP_W];
  assign iaddr = instr[adc_pkg::IADDR_LSB +: PW];
  assign prod = $signed(acc_q) * $signed(param_q[pc_q]);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pc_d = pc_q;
    running_d = running_q;
    acc_d = acc_q;
    out_l_d = out_l_q;
    out_r_d = out_r_q;
    in_l_d = in_l_q;
    in_r_d = in_r_q;
    init_done_d = init_done_q;
    dm.we = 1'b0;
    dm.waddr = iaddr;
    dm.wdata = acc_q;
    case (state_q)
      adc_pkg::ST_INIT: begin
        dm.we = 1'b1;
        dm.waddr = cnt_q[PW-1:0];
        dm.wdata = adc_pkg::ACC_RESET;
        cnt_d = cnt_q + 10'h001;
        if (cnt_q == adc_pkg::LEN_NORMAL - 10'h001) begin
          state_d = boot_s2_q ? adc_pkg::ST_RUN : adc_pkg::ST_WAIT;
          init_done_d = 1'b1;
        end
      end
      adc_pkg::ST_WAIT: begin
        state_d = adc_pkg::ST_WAIT;
        if (boot_s2_q) begin
          state_d = adc_pkg::ST_RUN;
        end
      end
      adc_pkg::ST_RUN: begin
        if (running_q) begin
          pc_d = pc_q + 9'h001;
          if ({1'b0, pc_q} >= pass_len - 10'h001) begin
            running_d = 1'b0;
          end
          case (op)
            adc_pkg::OP_LOAD_IN: acc_d = iaddr[0] ? in_r_q : in_l_q;
            adc_pkg::OP_LOAD_MEM: acc_d = dm.rdata;
            adc_pkg::OP_MUL_PARAM: acc_d = prod[CW+22:23];
            adc_pkg::OP_ADD_MEM: acc_d = acc_q + dm.rdata;
            adc_pkg::OP_STORE_MEM: dm.we = 1'b1;
            adc_pkg::OP_STORE_OUT: begin
              if (iaddr[0]) begin
                out_r_d = mute ? 24'h000000 : clip(acc_q);
              end else begin
                out_l_d = mute ? 24'h000000 : clip(acc_q);
              end
            end
            default: acc_d = acc_q;
          endcase
        end
        if (sample_strobe) begin
          pc_d = 9'h000;
          running_d = 1'b1;
          in_l_d = sext(in_left);
          in_r_d = sext(in_right);
        end
      end
      default: state_d = adc_pkg::ST_INIT;
    endcase
    // read one instruction ahead: data memory answers a cycle late
    dm.raddr = prog_q[pc_d][adc_pkg::IADDR_LSB +: PW];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= adc_pkg::ST_INIT;
      cnt_q <= 10'h000;
      pc_q <= 9'h000;
      running_q <= 1'b0;
      acc_q <= adc_pkg::ACC_RESET;
      out_l_q <= 24'h000000;
      out_r_q <= 24'h000000;
      in_l_q <= adc_pkg::ACC_RESET;
      in_r_q <= adc_pkg::ACC_RESET;
      init_done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pc_q <= pc_d;
      running_q <= running_d;
      acc_q <= acc_d;
      out_l_q <= out_l_d;
      out_r_q <= out_r_d;
      in_l_q <= in_l_d;
      in_r_q <= in_r_d;
      init_done_q <= init_done_d;
    end
  end

  // program and parameter memories: boot fill, then external loading
  always_ff @(posedge clk) begin
    if (state_q == adc_pkg::ST_INIT && !rst) begin
      prog_q[cnt_q[PW-1:0]] <= boot_instr(cnt_q[PW-1:0]);
      param_q[cnt_q[PW-1:0]] <= adc_pkg::UNITY;
    end else if (load_we && !boot_s2_q && init_done_q) begin
      if (load_sel) begin
        param_q[load_addr] <= load_data[CW-1:0];
      end else begin
        prog_q[load_addr] <= load_data;
      end
    end
  end

  assign init_done = init_done_q;
  assign out_left = out_l_q;
  assign out_right = out_r_q;
endmodule // adc_core

// ### verification/adc_core_properties.sv
/*
 adc_core_check: port timing checks for adc_core.
 assumes: bound to adc_core; pass-through is checked only while self_boot is high.
*/
`timescale 1ns/100ps
module adc_core_check (
  input wire logic clk, // clock
  input wire logic reset_active_low, // low resets
  input wire logic self_boot, // boot select pin
  input wire logic mute, // mute level
  input wire logic sample_strobe, // period start
  input wire logic [adc_pkg::SAMPLE_W-1:0] in_left, // left in
  input wire logic [adc_pkg::SAMPLE_W-1:0] in_right, // right in
  input wire logic init_done, // init over
  input wire logic [adc_pkg::SAMPLE_W-1:0] out_left, // left out
  input wire logic [adc_pkg::SAMPLE_W-1:0] out_right // right out
);
  logic [9:0] up_q, up_d, gap_q, gap_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_active_low);
  always_comb begin
    up_d = (up_q == 10'h3FF) ? up_q : up_q + 10'h001;
    gap_d = sample_strobe ? 10'h000 : (gap_q == 10'h3FF) ? gap_q : gap_q + 10'h001;
  end
  always_ff @(posedge clk) begin
    up_q <= reset_active_low ? up_d : 10'h000;
    gap_q <= reset_active_low ? gap_d : 10'h000;
  end
  sequence s_live;
    init_done && self_boot && up_q > 10'h220 && sample_strobe && !mute
      ##1 (!sample_strobe && !mute)[*6];
  endsequence
  sequence s_muted;
    init_done && sample_strobe && mute ##1 (!sample_strobe && mute)[*6];
  endsequence
  property p_init_low; (up_q < 10'h200) |-> !init_done; endproperty
  property p_init_high; (up_q == 10'h212) |-> init_done; endproperty
  property p_done_held; init_done |=> init_done; endproperty
  property p_zero_idle; !init_done |-> out_left == 24'h000000 && out_right == 24'h000000;
  endproperty
  property p_pass_left; s_live |-> out_left == $past(in_left, 6); endproperty
  property p_pass_right; s_live |-> out_right == $past(in_right, 6); endproperty
  property p_muted; s_muted |-> out_left == 24'h000000 && out_right == 24'h000000;
  endproperty
  property p_hold; (gap_q > 10'h008) |-> $stable(out_left) && $stable(out_right); endproperty
  a_init_low: assert property (p_init_low) else $error("init_done early");
  a_init_high: assert property (p_init_high) else $error("init_done late");
  a_done_held: assert property (p_done_held) else $error("init_done fell");
  a_zero_idle: assert property (p_zero_idle) else $error("output during init");
  a_pass_left: assert property (p_pass_left) else $error("left not passed");
  a_pass_right: assert property (p_pass_right) else $error("right not passed");
  a_muted: assert property (p_muted) else $error("muted output not zero");
  a_hold: assert property (p_hold) else $error("output moved between stores");
  c_live: cover property (s_live);
  c_muted: cover property (s_muted);
  c_done: cover property ($rose(init_done));
endmodule // adc_core_check

bind adc_core adc_core_check chk_u (.clk(clk), .reset_active_low(reset_active_low),
  .self_boot(self_boot),
  .mute(mute), .sample_strobe(sample_strobe), .in_left(in_left), .in_right(in_right),
  .init_done(init_done), .out_left(out_left), .out_right(out_right));

// ### verification/adc_src_model.sv
/*
 adc_src_model: serial input port stand-in, one strobe per sample period.
 assumes: bench sets period and next samples before the strobe.
*/
`timescale 1ns/100ps
module adc_src_model (
  input wire logic clk, // master clock
  input wire logic go, // run sample periods
  input wire logic [9:0] period, // cycles per sample
  input wire logic [23:0] l_req, // next left sample
  input wire logic [23:0] r_req, // next right sample
  output logic strobe, // period start
  output logic [23:0] in_left, // left sample
  output logic [23:0] in_right // right sample
);
  logic [9:0] cnt = 10'h000;
  logic hit;
  assign hit = go && (cnt + 10'h001 >= period);
  initial begin
    strobe = 1'b0;
    in_left = 24'h000000;
    in_right = 24'h000000;
  end
  always @(posedge clk) begin
    cnt <= (hit || !go) ? 10'h000 : cnt + 10'h001;
    strobe <= hit;
    // off the strobe the port shows garbage, not the last sample
    in_left <= hit ? l_req : ~in_left;
    in_right <= hit ? r_req : ~in_right;
  end
endmodule // adc_src_model

// ### verification/test_audio_dsp_core_datapath.sv
/*
 test_audio_dsp_core_datapath: table bench for adc_core.
 assumes: adc_src_model feeds samples; self boot high except in the external load test.
*/
`timescale 1ns/100ps
module test_audio_dsp_core_datapath;
  typedef struct packed {
    logic [1:0] rate;
    logic mute;
    logic [23:0] l, r, el, er;
  } adc_row_t;
  localparam adc_row_t ROWS [6] = '{
    '{2'h0, 1'b0, 24'h123456, 24'hFEDCBA, 24'h123456, 24'hFEDCBA},
    '{2'h1, 1'b0, 24'h7FFFFF, 24'h800000, 24'h7FFFFF, 24'h800000},
    '{2'h2, 1'b0, 24'h000001, 24'hFFFFFF, 24'h000001, 24'hFFFFFF},
    '{2'h3, 1'b0, 24'h400000, 24'hC00000, 24'h400000, 24'hC00000},
    '{2'h0, 1'b1, 24'h7FFFFF, 24'h800000, 24'h000000, 24'h000000},
    '{2'h2, 1'b1, 24'h0000AA, 24'h555555, 24'h000000, 24'h000000}};
  // doubled by the loaded program: both channels saturate
  localparam adc_row_t CLIP_ROW = '{2'h2, 1'b0, 24'h400000, 24'hA00000, 24'h7FFFFF, 24'h800000};
  logic clk = 1'b0;
  logic reset_active_low = 1'b0;
  logic mute = 1'b1;
  logic go = 1'b0;
  logic load_we = 1'b0;
  logic self_boot = 1'b1;
  logic load_sel = 1'b0;
  logic [31:0] load_data = 32'h00000000;
  logic [8:0] load_addr = 9'h000;
  logic [1:0] rate_sel = 2'h0;
  logic [9:0] period = 10'h200;
  logic [23:0] lq = 24'h000000;
  logic [23:0] rq = 24'h000000;
  logic strobe, init_done;
  logic [23:0] in_l, in_r, out_l, out_r;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  adc_src_model src_u (.clk(clk), .go(go), .period(period), .l_req(lq), .r_req(rq),
    .strobe(strobe), .in_left(in_l), .in_right(in_r));
  adc_core dut_u (.clk(clk), .reset_active_low(reset_active_low), .self_boot(self_boot),
    .rate_sel(rate_sel), .mute(mute), .sample_strobe(strobe), .in_left(in_l),
    .in_right(in_r), .load_we(load_we), .load_sel(load_sel), .load_addr(load_addr),
    .load_data(load_data), .init_done(init_done), .out_left(out_l), .out_right(out_r));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk({23'h000000, got}, {23'h000000, exp});
  endtask
  task automatic give_verdict();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic run(input adc_row_t w, input logic [9:0] p);
    int n;
    rate_sel <= w.rate;
    mute <= w.mute;
    lq <= w.l;
    rq <= w.r;
    period <= p;
    // first strobe may still carry the old sample
    repeat (2) begin
      n = 0;
      @(posedge clk);
      while (strobe !== 1'b1 && n < 600) begin
        @(posedge clk);
        n++;
      end
    end
    repeat (8) @(posedge clk);
    chk(out_l, w.el);
    chk(out_r, w.er);
  endtask
  // caller lowers load_we after the last word
  task automatic load_word(input logic sel, input logic [8:0] a, input logic [31:0] d);
    load_we <= 1'b1;
    load_sel <= sel;
    load_addr <= a;
    load_data <= d;
    @(posedge clk);
  endtask
  task automatic do_reset();
    int n;
    go <= 1'b0;
    self_boot <= 1'b1;
    reset_active_low <= 1'b0;
    repeat (12) @(posedge clk);
    chk_flag(init_done, 1'b0);
    chk(out_l, 24'h000000);
    reset_active_low <= 1'b1;
    repeat (400) @(posedge clk);
    chk_flag(init_done, 1'b0);
    n = 0;
    while (init_done !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk_flag(init_done, 1'b1);
    chk(out_r, 24'h000000);
    go <= 1'b1;
    $display("reset test done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    @(posedge clk);
    do_reset();
    for (int i = 0; i < 6; i++) begin
      run(ROWS[i], (ROWS[i].rate == 2'h1) ? adc_pkg::LEN_DOUBLE :
        (ROWS[i].rate == 2'h2) ? adc_pkg::LEN_QUAD : adc_pkg::LEN_NORMAL);
      $display("row %0d done", i);
    end
    load_we <= 1'b1;
    for (int a = 0; a < 512; a++) begin
      load_addr <= 9'(a);
      @(posedge clk);
    end
    load_we <= 1'b0;
    run(ROWS[1], adc_pkg::LEN_DOUBLE);
    $display("load refusal test done");
    run(ROWS[0], 10'h014);
    $display("restart test done");
    self_boot <= 1'b0;
    repeat (4) @(posedge clk);
    load_word(1'b0, 9'h001, {adc_pkg::OP_MUL_PARAM, 28'h0000000});
    load_word(1'b0, 9'h002, {adc_pkg::OP_STORE_OUT, 28'h0000000});
    load_word(1'b0, 9'h003, {adc_pkg::OP_LOAD_IN, 28'h0000001});
    load_word(1'b0, 9'h004, {adc_pkg::OP_MUL_PARAM, 28'h0000000});
    load_word(1'b0, 9'h005, {adc_pkg::OP_STORE_OUT, 28'h0000001});
    load_word(1'b1, 9'h001, 32'h01000000);
    load_word(1'b1, 9'h004, 32'h01000000);
    load_we <= 1'b0;
    run(CLIP_ROW, adc_pkg::LEN_QUAD);
    $display("external load and clip test done");
    do_reset();
    run(ROWS[2], adc_pkg::LEN_QUAD);
    $display("second reset test done");
    give_verdict();
  end
endmodule // test_audio_dsp_core_datapath
